// File: src/cache_id_pkg.sv
// constants for the cache identification and maintenance-address block
// assumes an AHB-Lite slave with 32-bit data, one word per register
package cache_id_pkg;

  // register byte offsets, decoded on the low address bits only
  localparam int           ADDR_W      = 8;
  localparam logic [7:0]   CFG_OFF     = 8'h00;
  localparam logic [7:0]   CACHE_TAG_LOW_OFF   = 8'h04;
  localparam logic [7:0]   CMD_OFF     = 8'h08;
  localparam logic [7:0]   RESULT_OFF  = 8'h0c;
  localparam logic [7:0]   STATUS_OFF  = 8'h10;

  // core_configuration field layout
  localparam int           EP_MSB      = 27;
  localparam int           EP_LSB      = 24;
  localparam int           CS_BIT      = 12;
  localparam int           IC_MSB      = 11;
  localparam int           IC_LSB      = 9;
  localparam int           DC_MSB      = 8;
  localparam int           DC_LSB      = 5;

  // cache capacities; size codes count doublings above one kilobyte
  localparam int           ICACHE_BYTES   = 4096;
  localparam int           DCACHE_BYTES   = 1024;
  localparam int           SIZE_CODE_BASE = 10;
  localparam logic [2:0]   ICACHE_CODE    =
    3'($clog2(ICACHE_BYTES) - SIZE_CODE_BASE);
  localparam logic [3:0]   DCACHE_CODE    =
    4'($clog2(DCACHE_BYTES) - SIZE_CODE_BASE);
  localparam logic         CS_SMALL       = 1'b1;

  // writeback transfer pattern: doubleword on every cycle
  localparam logic [3:0]   PATTERN_DD     = 4'h0;
  localparam logic [3:0]   PATTERN_RESET  = 4'h0;

  // cache data address ranges inside cache_tag_low
  localparam int           IC_TAG_MSB  = 31;
  localparam int           IC_TAG_LSB  = 12;
  localparam int           DC_TAG_MSB  = 13;
  localparam int           DC_TAG_LSB  = 10;
  localparam int           OP_ADDR_W   = IC_TAG_MSB - IC_TAG_LSB + 1;

  // maintenance command register
  localparam int           CMD_TARGET_BIT = 0;
  localparam logic         TARGET_DCACHE  = 1'b1;
  localparam int           OP_COUNT_W     = 16;

  // AHB-Lite
  localparam int           HTRANS_ACTIVE_BIT = 1;
  localparam logic         HRESP_OKAY        = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_e;

endpackage

// File: src/cache_addr_select.sv
// picks the cache data address out of cache_tag_low by target cache
// assumes a purely combinational use inside the register block
`timescale 1ns/1ns
module cache_addr_select (
  input  wire logic [31:0]                       tagLow,   // tag-low word
  input  wire logic                              dcache,   // 1: data cache
  output logic [cache_id_pkg::OP_ADDR_W-1:0]     dataAddr  // cache address
);

  localparam int DC_W =
    cache_id_pkg::DC_TAG_MSB - cache_id_pkg::DC_TAG_LSB + 1;

  always_comb begin
    if (dcache) begin
      // data cache address sits low, zero above
      dataAddr = {{(cache_id_pkg::OP_ADDR_W - DC_W){1'b0}},
                  tagLow[cache_id_pkg::DC_TAG_MSB:
                         cache_id_pkg::DC_TAG_LSB]};
    end else begin
      dataAddr =
        tagLow[cache_id_pkg::IC_TAG_MSB:cache_id_pkg::IC_TAG_LSB];
    end
  end

endmodule // cache_addr_select

// File: src/cache_config_identification.sv
// cache identification and maintenance-address register block
// assumes one AHB-Lite master, single word transfers, core clock and reset
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module cache_config_identification #(
  parameter int HADDR_W = 32
) (
  input  wire logic               clk,              // core clock
  input  wire logic               arst_n,           // async reset, low
  input  wire logic               hsel,             // slave select
  input  wire logic [HADDR_W-1:0] haddr,            // byte address
  input  wire logic [1:0]         htrans,           // transfer type
  input  wire logic               hwrite,           // 1: write
  input  wire logic [2:0]         hsize,            // word only
  input  wire logic [31:0]        hwdata,           // write data
  input  wire logic               hready,           // bus ready
  output logic [31:0]             hrdata,           // read data
  output logic                    hreadyout,        // slave ready
  output logic                    hresp,            // always okay
  output logic                    cacheOpValid,     // maintenance pulse
  output logic                    cacheOpDcache,    // 1: data cache
  output logic [19:0]             cacheOpAddr,      // cache data address
  output logic [3:0]              writebackPattern  // writeback pattern
);

  localparam int AW = cache_id_pkg::ADDR_W;
  localparam int OW = cache_id_pkg::OP_ADDR_W;
  localparam int CW = cache_id_pkg::OP_COUNT_W;

  cache_id_pkg::bus_state_e busState_reg;
  cache_id_pkg::bus_state_e busState_next;
  logic          wrPend_reg;
  logic          wrPend_next;
  logic [AW-1:0] wrAddr_reg;
  logic [AW-1:0] wrAddr_next;
  logic [AW-1:0] rdAddr_reg;
  logic [AW-1:0] rdAddr_next;
  logic [31:0]   hrdata_reg;
  logic [31:0]   hrdata_next;
  logic          hreadyout_reg;
  logic          hreadyout_next;
  logic [3:0]    pattern_reg;
  logic [3:0]    pattern_next;
  logic [31:0]   tagLow_reg;
  logic [31:0]   tagLow_next;
  logic          opValid_reg;
  logic          opValid_next;
  logic          opDcache_reg;
  logic          opDcache_next;
  logic [OW-1:0] opAddr_reg;
  logic [OW-1:0] opAddr_next;
  logic [CW-1:0] opCount_reg;
  logic [CW-1:0] opCount_next;

  logic          take;
  logic [31:0]   cfgWord;
  logic [OW-1:0] selAddr;
  logic          patternLegal;

  // address phase is taken only when the bus is ready
  assign take = hsel && htrans[cache_id_pkg::HTRANS_ACTIVE_BIT] && hready;

  // size fields are constants, not storage, so writes cannot reach them
  always_comb begin
    cfgWord = 32'h0;
    cfgWord[cache_id_pkg::EP_MSB:cache_id_pkg::EP_LSB] = pattern_reg;
    cfgWord[cache_id_pkg::CS_BIT] = cache_id_pkg::CS_SMALL;
    cfgWord[cache_id_pkg::IC_MSB:cache_id_pkg::IC_LSB] =
      cache_id_pkg::ICACHE_CODE;
    cfgWord[cache_id_pkg::DC_MSB:cache_id_pkg::DC_LSB] =
      cache_id_pkg::DCACHE_CODE;
  end

  // only the documented pattern is legal; others are reported, not fixed
  assign patternLegal = (pattern_reg == cache_id_pkg::PATTERN_DD);

  cache_addr_select u_addr_select (
    .tagLow   (tagLow_reg),
    .dcache   (hwdata[cache_id_pkg::CMD_TARGET_BIT]),
    .dataAddr (selAddr)
  );

  // bus handshake: writes zero wait, reads one wait so that a write in
  // the preceding data phase is always visible
  always_comb begin
    busState_next  = busState_reg;
    rdAddr_next    = rdAddr_reg;
    hrdata_next    = hrdata_reg;
    hreadyout_next = hreadyout_reg;
    wrPend_next    = 1'b0;
    wrAddr_next    = wrAddr_reg;
    unique case (busState_reg)
      cache_id_pkg::BUS_IDLE: begin
        if (take && !hwrite) begin
          busState_next  = cache_id_pkg::BUS_READ;
          rdAddr_next    = haddr[AW-1:0];
          hreadyout_next = 1'b0;
        end else if (take) begin
          wrPend_next = 1'b1;
          wrAddr_next = haddr[AW-1:0];
        end
      end
      cache_id_pkg::BUS_READ: begin
        busState_next  = cache_id_pkg::BUS_IDLE;
        hreadyout_next = 1'b1;
        unique case (rdAddr_reg)
          cache_id_pkg::CFG_OFF:    hrdata_next = cfgWord;
          cache_id_pkg::CACHE_TAG_LOW_OFF:  hrdata_next = tagLow_reg;
          cache_id_pkg::CMD_OFF:    hrdata_next = {31'h0, opDcache_reg};
          cache_id_pkg::RESULT_OFF: hrdata_next =
            {opDcache_reg, 11'h0, opAddr_reg};
          cache_id_pkg::STATUS_OFF: hrdata_next =
            {patternLegal, 15'h0, opCount_reg};
          default:                  hrdata_next = 32'h0;
        endcase
      end
    endcase
  end

  // register writes land in the data phase after the address phase
  always_comb begin
    pattern_next  = pattern_reg;
    tagLow_next   = tagLow_reg;
    opValid_next  = 1'b0;
    opDcache_next = opDcache_reg;
    opAddr_next   = opAddr_reg;
    opCount_next  = opCount_reg;
    if (wrPend_reg) begin
      unique case (wrAddr_reg)
        cache_id_pkg::CFG_OFF: begin
          // only the pattern field is storage
          pattern_next =
            hwdata[cache_id_pkg::EP_MSB:cache_id_pkg::EP_LSB];
        end
        cache_id_pkg::CACHE_TAG_LOW_OFF: begin
          tagLow_next = hwdata;
        end
        cache_id_pkg::CMD_OFF: begin
          opValid_next  = 1'b1;
          opDcache_next = hwdata[cache_id_pkg::CMD_TARGET_BIT];
          opAddr_next   = selAddr;
          opCount_next  = opCount_reg + CW'(1);
        end
        default: begin
          // unmapped or read-only: write dropped
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busState_reg  <= cache_id_pkg::BUS_IDLE;
      rdAddr_reg    <= 8'h00;
      hrdata_reg    <= 32'h0;
      hreadyout_reg <= 1'b1;
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
    end else begin
      busState_reg  <= busState_next;
      rdAddr_reg    <= rdAddr_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= hreadyout_next;
      wrPend_reg    <= wrPend_next;
      wrAddr_reg    <= wrAddr_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_reg  <= cache_id_pkg::PATTERN_RESET;
      tagLow_reg   <= 32'h0;
      opValid_reg  <= 1'b0;
      opDcache_reg <= 1'b0;
      opAddr_reg   <= 20'h0;
      opCount_reg  <= 16'h0;
    end else begin
      pattern_reg  <= pattern_next;
      tagLow_reg   <= tagLow_next;
      opValid_reg  <= opValid_next;
      opDcache_reg <= opDcache_next;
      opAddr_reg   <= opAddr_next;
      opCount_reg  <= opCount_next;
    end
  end

  assign hrdata           = hrdata_reg;
  assign hreadyout        = hreadyout_reg;
  assign hresp            = cache_id_pkg::HRESP_OKAY;
  assign cacheOpValid     = opValid_reg;
  assign cacheOpDcache    = opDcache_reg;
  assign cacheOpAddr      = opAddr_reg;
  assign writebackPattern = pattern_reg;

  // read of core_configuration completes on the rise of hreadyout
  property p_cs_small;
    @(posedge clk) disable iff (!arst_n)
    ($rose(hreadyout) && rdAddr_reg == 8'h00) |-> hrdata[12] == 1'b1;
  endproperty
  a_cs_small: assert property (p_cs_small)
    else $error("cache size mode bit not one");

  property p_ic_code;
    @(posedge clk) disable iff (!arst_n)
    ($rose(hreadyout) && rdAddr_reg == 8'h00) |-> hrdata[11:9] == 3'h2;
  endproperty
  a_ic_code: assert property (p_ic_code)
    else $error("icache size code not 010");

  property p_dc_code;
    @(posedge clk) disable iff (!arst_n)
    ($rose(hreadyout) && rdAddr_reg == 8'h00) |-> hrdata[8:5] == 4'h0;
  endproperty
  a_dc_code: assert property (p_dc_code)
    else $error("dcache size code not zero");

  property p_sizes;
    @(posedge clk) disable iff (!arst_n)
    (take && !hwrite && haddr[7:0] == 8'h00)
      |=> !hreadyout ##1 (hreadyout && hrdata[12:5] == 8'ha0);
  endproperty
  a_sizes: assert property (p_sizes)
    else $error("config read lacks 4K/1K size fields");

  property p_ic_addr;
    @(posedge clk) disable iff (!arst_n)
    (cacheOpValid && !cacheOpDcache)
      |-> cacheOpAddr == $past(tagLow_reg[31:12]);
  endproperty
  a_ic_addr: assert property (p_ic_addr)
    else $error("icache address not tag bits 31..12");

  property p_dc_addr;
    @(posedge clk) disable iff (!arst_n)
    (cacheOpValid && cacheOpDcache)
      |-> cacheOpAddr == {16'h0, $past(tagLow_reg[13:10])};
  endproperty
  a_dc_addr: assert property (p_dc_addr)
    else $error("dcache address not tag bits 13..10");

  property p_ro_fields;
    @(posedge clk) disable iff (!arst_n)
    (wrPend_reg && wrAddr_reg == 8'h00)
      |=> (cfgWord[12:5] == $past(cfgWord[12:5]))
          && (writebackPattern == $past(hwdata[27:24]));
  endproperty
  a_ro_fields: assert property (p_ro_fields)
    else $error("config write touched size fields or lost pattern");

  property p_op_pulse;
    @(posedge clk) disable iff (!arst_n)
    (wrPend_reg && wrAddr_reg == cache_id_pkg::CMD_OFF)
      |=> cacheOpValid;
  endproperty
  a_op_pulse: assert property (p_op_pulse)
    else $error("maintenance pulse missing after command write");

  // back to back commands legally keep the pulse high, so judge per cycle
  property p_op_only;
    @(posedge clk) disable iff (!arst_n)
    !(wrPend_reg && wrAddr_reg == cache_id_pkg::CMD_OFF) |=> !cacheOpValid;
  endproperty
  a_op_only: assert property (p_op_only)
    else $error("maintenance pulse without a command write");

  property p_read_wait;
    @(posedge clk) disable iff (!arst_n)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read did not take exactly one wait state");

  property p_write_nowait;
    @(posedge clk) disable iff (!arst_n)
    (take && hwrite) |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write data phase was stretched");

  property p_pattern_hold;
    @(posedge clk) disable iff (!arst_n)
    !(wrPend_reg && wrAddr_reg == cache_id_pkg::CFG_OFF)
      |=> $stable(writebackPattern);
  endproperty
  a_pattern_hold: assert property (p_pattern_hold)
    else $error("pattern changed without a config write");

  property p_count_step;
    @(posedge clk) disable iff (!arst_n)
    (wrPend_reg && wrAddr_reg == cache_id_pkg::CMD_OFF)
      |=> opCount_reg == $past(opCount_reg) + CW'(1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("op count did not step by one");

  property p_rdata_hold;
    @(posedge clk) disable iff (!arst_n)
    (busState_reg == cache_id_pkg::BUS_IDLE) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read");

endmodule // cache_config_identification

// File: sim/cache_config_identification_tb_top.sv
// self-checking bench for the cache identification register block
// assumes the block is the only AHB-Lite slave, hready tied to hreadyout
`timescale 1ns/1ns
module cache_config_identification_tb_top;
  logic        clk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyBus;
  logic [31:0] hrdata;
  logic        hresp;
  logic        cacheOpValid;
  logic        cacheOpDcache;
  logic [19:0] cacheOpAddr;
  logic [3:0]  writebackPattern;
  int          fails;
  int          checked;

  cache_config_identification dut_u (
    .clk              (clk),
    .arst_n           (arst_n),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyBus),
    .hrdata           (hrdata),
    .hreadyout        (hreadyBus),
    .hresp            (hresp),
    .cacheOpValid     (cacheOpValid),
    .cacheOpDcache    (cacheOpDcache),
    .cacheOpAddr      (cacheOpAddr),
    .writebackPattern (writebackPattern)
  );

  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hreadyBus !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    // only the watchdog ends a wait; reads take one wait, writes none
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyBus !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response not okay");
    chk(32'(n), w ? 32'h1 : 32'h2, "data phase length");
  endtask

  task automatic test_reset_ids();
    logic [31:0] rd;
    chk({28'h0, writebackPattern}, 32'h0, "pattern after reset");
    xfer(1'b0, 8'h00, 32'h0, rd);
    chk({31'h0, rd[12]}, 32'h1, "size mode bit");
    chk({29'h0, rd[11:9]}, 32'h2, "icache size code");
    chk({28'h0, rd[8:5]}, 32'h0, "dcache size code");
    chk(rd, 32'h00001400, "config reset word");
  endtask

  task automatic test_config_write();
    logic [31:0] rd;
    // ones everywhere but the pattern, which software keeps at doubleword
    xfer(1'b1, 8'h00, 32'hf0ffffff, rd);
    xfer(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00001400, "size fields not fixed");
    chk({28'h0, writebackPattern}, 32'h0, "pattern output");
    xfer(1'b0, 8'h10, 32'h0, rd);
    chk({31'h0, rd[31]}, 32'h1, "pattern flag");
    // zeros must not clear the fixed size fields either
    xfer(1'b1, 8'h00, 32'h00000000, rd);
    xfer(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00001400, "config after clear");
    chk({28'h0, writebackPattern}, 32'h0, "pattern cleared");
  endtask

  // set tag-low, fire one op, check pulse, target and address
  task automatic run_op(input logic [31:0] tag, input logic dc,
                        input logic [19:0] exp);
    logic [31:0] rd;
    xfer(1'b1, 8'h04, tag, rd);
    xfer(1'b0, 8'h04, 32'h0, rd);
    chk(rd, tag, "tag-low readback");
    xfer(1'b1, 8'h08, {31'h0, dc}, rd);
    @(posedge clk);
    chk({31'h0, cacheOpValid}, 32'h1, "op pulse missing");
    chk({31'h0, cacheOpDcache}, {31'h0, dc}, "op target");
    chk(32'(cacheOpAddr), 32'(exp), "op address");
    @(posedge clk);
    chk({31'h0, cacheOpValid}, 32'h0, "op pulse too long");
    xfer(1'b0, 8'h08, 32'h0, rd);
    chk(rd, {31'h0, dc}, "command readback");
    xfer(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, {dc, 11'h0, exp}, "result register");
  endtask

  task automatic test_ops();
    logic [31:0] rd;
    run_op(32'ha5a53c00, 1'b0, 20'ha5a53);
    run_op(32'h00002c00, 1'b1, 20'h0000b);
    run_op(32'hffffdfff, 1'b1, 20'h00007);
    run_op(32'h00000fff, 1'b0, 20'h00000);
    xfer(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h80000004, "status count and flag");
  endtask

  task automatic test_unmapped();
    logic [31:0] rd;
    xfer(1'b1, 8'h20, 32'hdeadbeef, rd);
    xfer(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    xfer(1'b1, 8'h0c, 32'hffffffff, rd);
    xfer(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0, "result register written");
    xfer(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00001400, "config disturbed");
  endtask

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk    = 1'b0;
    arst_n = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    fails  = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    test_reset_ids();
    test_config_write();
    test_ops();
    test_unmapped();
    summarize();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #(8 * 20000);
    fails++;
    summarize();
  end
endmodule // cache_config_identification_tb_top
